// ===== src/dpt_pkg.sv
package dpt_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 25;
    localparam int TICK_PERIOD_US = 12500;  // 80 pps translation ticks
    localparam int TICK_CYCLES    = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int HOLD_REL_MS    = 800;
    localparam int HOLD_TICKS     = HOLD_REL_MS * 1000 / TICK_PERIOD_US;
    localparam int HOLD_W         = 8;
    // strobe positions inside one tick period
    localparam int PH_READ        = 0;
    localparam int PH_WRITE       = 1;
    localparam int PH_SHARED      = 2;
    // ----------------------------------------------------------------
    // stepping chain and shift register
    // ----------------------------------------------------------------
    localparam int DIV_STAGES     = 8;
    localparam int SR_STAGES      = 16;
    localparam int ST_TRIGGER     = 0;
    localparam int ST_ODD         = 1;
    localparam int ST_LAST_PULSE  = 11;
    localparam int ST_SHORT_TIME  = 12;
    localparam int ST_FINAL       = 15;
    localparam int ENTRY_BASE     = 12;    // entry stage = base - weight
    // amplifier weight lines
    localparam int AMP_W          = 6;
    localparam int W_ONE          = 0;
    localparam int W_TWO          = 1;
    localparam int W_FOUR         = 2;
    localparam int W_SIX          = 3;
    localparam int W_EIGHT        = 4;
    localparam int W_TEN          = 5;
    // ----------------------------------------------------------------
    // apb map
    // ----------------------------------------------------------------
    localparam int          APB_AW     = 8;
    localparam logic [7:0]  ADDR_CTRL  = 8'h00;
    localparam logic [7:0]  ADDR_STAT  = 8'h04;
    localparam logic [7:0]  ADDR_SHIFT = 8'h08;
    localparam logic [7:0]  ADDR_TRIGS = 8'h0C;
    localparam int          CTRL_EN    = 0;
    localparam int          CTRL_SEIZE = 1;
    localparam int          STAT_ARM   = 0;
    localparam int          STAT_HOLD  = 1;
    localparam int          STAT_EARM  = 2;
    localparam int          STAT_RESUM = 3;
    localparam int          TRIG_W     = 16;
endpackage : dpt_pkg

// ===== src/dpt_divider.sv
`timescale 1ns/10ps
module dpt_divider #(
    parameter int RING_STAGES = dpt_pkg::DIV_STAGES
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    // control
    input  wire logic clear,
    input  wire logic tick,
    // shift advance phases
    output logic      adv_a,
    output logic      adv_b
);
    import dpt_pkg::*;

    localparam logic [RING_STAGES-1:0] RING_INIT = RING_STAGES'(1);

    logic                   div_dist_q;
    logic [RING_STAGES-1:0] ring_q;
    logic                   tr_dist_q;
    logic                   div_lo;
    logic                   div_hi;
    logic                   ring_out;

    // divider distributor alternates its two outputs
    assign div_lo   = tick & ~div_dist_q;
    assign div_hi   = tick & div_dist_q;
    assign ring_out = (div_lo | div_hi) & ring_q[RING_STAGES-1];
    assign adv_a    = ring_out & ~tr_dist_q;
    assign adv_b    = ring_out & tr_dist_q;

    // divider distributor toggle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_dist_q <= 1'b0;
        end else if (clk_en) begin
            if (clear) div_dist_q <= 1'b0;
            else if (tick) div_dist_q <= ~div_dist_q;
        end
    end

    // eight stage ring, one output per full turn
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ring_q <= RING_INIT;
        end else if (clk_en) begin
            if (clear) ring_q <= RING_INIT;
            else if (div_lo | div_hi)
                ring_q <= {ring_q[RING_STAGES-2:0], ring_q[RING_STAGES-1]};
        end
    end

    // translation distributor toggle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tr_dist_q <= 1'b0;
        end else if (clk_en) begin
            if (clear) tr_dist_q <= 1'b0;
            else if (ring_out) tr_dist_q <= ~tr_dist_q;
        end
    end
endmodule : dpt_divider

// ===== src/dpt_translator.sv
// Function
// - seizure clears translation arm, stays idle
// - amplifier fire arms; write strobes then tick
// - ticks recur at 80 pps, stop after call
// - end-of-digit disarms, overriding re-arm
// - final output arms end gate; next advance ends
// - divider distributor resets defined, alternates outputs
// - eight-stage ring gives one output per eight
// - translation distributor alternates two 5 pps phases
// - digit marks one stage by its weight
// - pulsing-stage advance, then read strobe triggers
// - eleven pulsing stages, then silent timing stages
// - last stage, end-of-digit, next digit spacing
// - odd digit adds first pulsing stage mark
// - digit one marks first and short-timing stages
// - hold relay asserts at first tick
// - hold relay drops 800 msec after ticks
// - write-phase resume pulse to read control
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module dpt_translator #(
    parameter int TICK_CYCLES = dpt_pkg::TICK_CYCLES
) (
    // clock, reset, enable
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         clk_en,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [dpt_pkg::APB_AW-1:0]   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // read side
    input  wire logic                         seize,
    input  wire logic [dpt_pkg::AMP_W-1:0]    amp_fire,
    output logic                              read_resume,
    // line side
    output logic                              pulse_trigger,
    output logic                              digit_end,
    output logic                              interface_hold_relay
);
    import dpt_pkg::*;

    localparam int PH_W = $clog2(TICK_CYCLES);
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(TICK_CYCLES - 1);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // stage marked by one weight line
    function automatic logic [SR_STAGES-1:0] weight_mark(input int w);
        weight_mark = SR_STAGES'(1) << (ENTRY_BASE - w);
    endfunction : weight_mark

    // marks placed by a digit on the weight lines
    function automatic logic [SR_STAGES-1:0] entry_marks(input logic [AMP_W-1:0] a);
        logic [SR_STAGES-1:0] m;
        m = '0;
        if (a[W_TWO])   m = m | weight_mark(2);
        if (a[W_FOUR])  m = m | weight_mark(4);
        if (a[W_SIX])   m = m | weight_mark(6);
        if (a[W_EIGHT]) m = m | weight_mark(8);
        if (a[W_TEN])   m = m | weight_mark(10);
        if (a[W_ONE]) begin
            m[ST_ODD] = 1'b1;
            if (a[AMP_W-1:W_TWO] == '0) m[ST_SHORT_TIME] = 1'b1;
        end
        entry_marks = m;
    endfunction : entry_marks

    // stages that move on a given advance phase
    function automatic logic [SR_STAGES-1:0] moving(input logic a, input logic b);
        logic [SR_STAGES-1:0] mv;
        mv = '0;
        for (int i = ST_ODD; i < SR_STAGES; i++) mv[i] = (i % 2 == 1) ? a : b;
        moving = mv;
    endfunction : moving

    // ----------------------------------------------------------------
    // strobe distributor
    // ----------------------------------------------------------------
    logic [PH_W-1:0] ph_q;
    logic            read_phase_strobe;
    logic            write_phase_strobe;
    logic            shared_phase_strobe;

    // one read, write and shared strobe per tick period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ph_q <= '0;
        else if (clk_en) ph_q <= (ph_q == PH_LAST) ? '0 : ph_q + 1'b1;
    end

    assign read_phase_strobe   = clk_en & (ph_q == PH_W'(PH_READ));
    assign write_phase_strobe  = clk_en & (ph_q == PH_W'(PH_WRITE));
    assign shared_phase_strobe = clk_en & (ph_q == PH_W'(PH_SHARED));

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    logic              ctrl_en_q;
    logic              soft_seize_q;
    logic [TRIG_W-1:0] trig_cnt_q;
    logic              wr_acc;
    logic              setup;
    logic              hit;
    logic [31:0]       rd_mux;
    logic              seize_all;

    logic                 arm_q;
    logic                 end_arm_q;
    logic                 resume_pend_q;
    logic [SR_STAGES-1:0] sr_q;
    logic                 hold_q;
    logic [HOLD_W-1:0]    hold_cnt_q;

    assign pready    = 1'b1;
    assign wr_acc    = psel & penable & pwrite & clk_en;
    assign setup     = psel & ~penable & clk_en;
    assign seize_all = seize | soft_seize_q;

    // read decode
    always_comb begin
        rd_mux = '0;
        hit    = 1'b1;
        case (paddr)
            ADDR_CTRL:  rd_mux[CTRL_EN] = ctrl_en_q;
            ADDR_STAT: begin
                rd_mux[STAT_ARM]   = arm_q;
                rd_mux[STAT_HOLD]  = hold_q;
                rd_mux[STAT_EARM]  = end_arm_q;
                rd_mux[STAT_RESUM] = resume_pend_q;
            end
            ADDR_SHIFT: rd_mux[SR_STAGES-1:0] = sr_q;
            ADDR_TRIGS: rd_mux[TRIG_W-1:0] = trig_cnt_q;
            default:    hit = 1'b0;
        endcase
    end

    // read data and error latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? '0 : rd_mux;
            pslverr <= ~hit;
        end
    end

    // control register, seize bit self clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_q    <= 1'b1;
            soft_seize_q <= 1'b0;
        end else if (clk_en) begin
            soft_seize_q <= wr_acc & (paddr == ADDR_CTRL) & pwdata[CTRL_SEIZE];
            if (wr_acc && paddr == ADDR_CTRL) ctrl_en_q <= pwdata[CTRL_EN];
        end
    end

    // ----------------------------------------------------------------
    // translation control
    // ----------------------------------------------------------------
    logic                 tick;
    logic                 adv_a;
    logic                 adv_b;
    logic                 advance;
    logic                 digit_in;
    logic                 end_fire;
    logic [SR_STAGES-1:0] mv;
    logic [SR_STAGES-1:0] leaving;
    logic [SR_STAGES-1:0] sr_d;
    logic                 pulse_leave;
    logic                 final_out;

    assign digit_in = read_phase_strobe & ctrl_en_q & (|amp_fire);
    assign tick     = write_phase_strobe & arm_q;
    assign advance  = adv_a | adv_b;
    assign end_fire = advance & end_arm_q;

    dpt_divider #(
        .RING_STAGES (DIV_STAGES)
    ) u_divider (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .clear   (seize_all),
        .tick    (tick),
        .adv_a   (adv_a),
        .adv_b   (adv_b)
    );

    // translation arm core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_q <= 1'b0;
        end else if (clk_en) begin
            if (seize_all) arm_q <= 1'b0;
            else if (end_fire) arm_q <= 1'b0;
            else if (digit_in) arm_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // marking shift register
    // ----------------------------------------------------------------
    // two-phase shift: odd stages move on phase a, even stages from 2 up on phase b, trigger stage 0 never shifts
    always_comb begin
        mv      = moving(adv_a, adv_b);
        leaving = sr_q & mv;
        sr_d    = sr_q & ~mv;
        for (int i = ST_ODD + 1; i <= ST_FINAL; i++) begin
            if (i - 1 != ST_ODD) sr_d[i] = sr_d[i] | leaving[i-1];
        end
        pulse_leave = |leaving[ST_LAST_PULSE:ST_ODD];
        final_out   = leaving[ST_FINAL];
        if (pulse_leave) sr_d[ST_TRIGGER] = 1'b1;
        else if (read_phase_strobe) sr_d[ST_TRIGGER] = 1'b0;
        if (digit_in) sr_d = sr_d | entry_marks(amp_fire);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sr_q <= '0;
        else if (clk_en) sr_q <= seize_all ? '0 : sr_d;
    end

    // trigger restored on read strobe gives one dial pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_trigger <= 1'b0;
            trig_cnt_q    <= '0;
        end else if (clk_en) begin
            pulse_trigger <= read_phase_strobe & sr_q[ST_TRIGGER] & ~seize_all;
            if (seize_all) trig_cnt_q <= '0;
            else if (read_phase_strobe && sr_q[ST_TRIGGER])
                trig_cnt_q <= trig_cnt_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // end of digit and read resume
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            end_arm_q <= 1'b0;
            digit_end <= 1'b0;
        end else if (clk_en) begin
            digit_end <= end_fire & ~seize_all;
            if (seize_all || (end_fire && !final_out)) end_arm_q <= 1'b0;  // set wins
            else if (final_out) end_arm_q <= 1'b1;
        end
    end

    // resume pulse goes out on the next write strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resume_pend_q <= 1'b0;
            read_resume   <= 1'b0;
        end else if (clk_en) begin
            read_resume <= write_phase_strobe & resume_pend_q & ~seize_all;
            if (seize_all) resume_pend_q <= 1'b0;
            else if (end_fire) resume_pend_q <= 1'b1;
            else if (write_phase_strobe) resume_pend_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // interface hold relay
    // ----------------------------------------------------------------
    // counted in tick periods after the last tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q     <= 1'b0;
            hold_cnt_q <= '0;
        end else if (clk_en) begin
            if (seize_all) begin
                hold_q     <= 1'b0;
                hold_cnt_q <= '0;
            end else if (tick) begin
                hold_q     <= 1'b1;
                hold_cnt_q <= '0;
            end else if (hold_q && shared_phase_strobe) begin
                if (hold_cnt_q == HOLD_W'(HOLD_TICKS - 1)) hold_q <= 1'b0;
                hold_cnt_q <= hold_cnt_q + 1'b1;
            end
        end
    end

    assign interface_hold_relay = hold_q;
endmodule : dpt_translator

// ===== testbench/dpt_translator_sva.sv
`timescale 1ns/10ps
module dpt_translator_sva
    import dpt_pkg::*;
#(
    parameter int TICK_CYCLES = dpt_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       clk_en,
    // apb
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic [dpt_pkg::APB_AW-1:0] paddr,
    input wire logic                       pslverr,
    // digit and line side
    input wire logic                       seize,
    input wire logic                       read_resume,
    input wire logic                       pulse_trigger,
    input wire logic                       digit_end,
    input wire logic                       interface_hold_relay
);
    import dpt_pkg::*;
    localparam int ADV = 8 * TICK_CYCLES;
    logic [31:0] trig_gap_q;
    logic [31:0] end_gap_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    // cycles since the last trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) trig_gap_q <= 32'h0000_0000;
        else if (pulse_trigger) trig_gap_q <= 32'h0000_0000;
        else if (clk_en) trig_gap_q <= trig_gap_q + 32'h0000_0001;
    end
    // cycles since the last end of digit, starts far away
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) end_gap_q <= 32'hFFFF_0000;
        else if (digit_end) end_gap_q <= 32'h0000_0000;
        else if (clk_en) end_gap_q <= end_gap_q + 32'h0000_0001;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_trig_single: assert property (pulse_trigger |=> !pulse_trigger)
        else $error("trigger wider than one cycle");
    a_end_single: assert property (digit_end |=> !digit_end)
        else $error("end of digit wider than one cycle");
    a_trig_spacing: assert property (pulse_trigger |-> trig_gap_q >= ADV - 1)
        else $error("triggers closer than one shift advance");
    a_end_timing: assert property (digit_end |->
        trig_gap_q inside {[32 * TICK_CYCLES : 40 * TICK_CYCLES]})
        else $error("end of digit not five advances after last pulse");
    a_hold_release: assert property ($fell(interface_hold_relay) && !$past(seize) |->
        trig_gap_q inside {[HOLD_TICKS * TICK_CYCLES : (HOLD_TICKS + 48) * TICK_CYCLES]})
        else $error("hold dropped at wrong time");
    a_resume_after: assert property (read_resume |-> end_gap_q < TICK_CYCLES + 2)
        else $error("resume not on the write strobe after end of digit");
    a_hold_pulsing: assert property (pulse_trigger || digit_end |-> interface_hold_relay)
        else $error("pulsing without hold");
    a_seize_quiet: assert property (seize |=>
        (!pulse_trigger && !digit_end && !read_resume) [*8])
        else $error("activity after seizure");
    a_err_unmapped: assert property (psel && !penable && clk_en && paddr >= 8'h10 |=> pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (psel && !penable && clk_en && paddr < 8'h10
        && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("error on mapped address");

    c_trigger: cover property (pulse_trigger);
    c_digit_end: cover property (digit_end);
    c_hold_drop: cover property ($fell(interface_hold_relay));
endmodule : dpt_translator_sva

bind dpt_translator dpt_translator_sva #(.TICK_CYCLES(TICK_CYCLES)) dpt_translator_sva_inst (
    .pclk                 (pclk),
    .presetn              (presetn),
    .clk_en               (clk_en),
    .psel                 (psel),
    .penable              (penable),
    .paddr                (paddr),
    .pslverr              (pslverr),
    .seize                (seize),
    .read_resume          (read_resume),
    .pulse_trigger        (pulse_trigger),
    .digit_end            (digit_end),
    .interface_hold_relay (interface_hold_relay)
);

// ===== testbench/dpt_pulse_gen.sv
`timescale 1ns/10ps
module dpt_pulse_gen #(
    parameter int BREAK_CYC = 77,
    parameter int MAKE_CYC  = 51
) (
    // clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // trigger in, relay out
    input  wire logic   pulse_trigger,
    output logic        line_pulsing_relay,
    output logic [15:0] break_count
);
    logic [15:0] cnt_q;
    // ------------------------------------------------------------
    // one-shot: break then make for each trigger
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q       <= 16'h0000;
            break_count <= 16'h0000;
        end else if (pulse_trigger && cnt_q == 16'h0000) begin
            // loading edge counts too, so the shot is idle again one period on
            cnt_q       <= 16'(BREAK_CYC + MAKE_CYC - 1);
            break_count <= break_count + 16'h0001;
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end
    // relay released during the break, operated otherwise
    assign line_pulsing_relay = !(cnt_q >= 16'(MAKE_CYC));
endmodule : dpt_pulse_gen

// ===== testbench/tb_dpt_translator.sv
`timescale 1ns/10ps
module tb_dpt_translator;
    import dpt_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int TC  = 16;
    localparam int ADV = 8 * TC;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, seize, pready, pslverr, err, clk_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  amp_fire;
    logic        read_resume, pulse_trigger, digit_end, interface_hold_relay, relay;
    logic [15:0] brk_cnt;
    int          bad_count = 0, n_tests = 0, trig_n = 0, end_n = 0, res_n = 0, cum, t0, n;
    logic [5:0]  fire_tab [10] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
                                   6'h08, 6'h09, 6'h10, 6'h11, 6'h20};

    always #12.5 pclk = ~pclk;

    dpt_translator #(.TICK_CYCLES(TC)) dpt_translator_inst (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .seize(seize), .amp_fire(amp_fire), .read_resume(read_resume),
        .pulse_trigger(pulse_trigger), .digit_end(digit_end),
        .interface_hold_relay(interface_hold_relay));
    dpt_pulse_gen dpt_pulse_gen_inst (
        .pclk(pclk), .presetn(presetn), .pulse_trigger(pulse_trigger),
        .line_pulsing_relay(relay), .break_count(brk_cnt));

    // counts the one-cycle outputs
    always @(posedge pclk) begin
        if (pulse_trigger === 1'b1) trig_n <= trig_n + 1;
        if (digit_end === 1'b1) end_n <= end_n + 1;
        if (read_resume === 1'b1) res_n <= res_n + 1;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rdchk

    // weight lines held one full tick period: exactly one read strobe
    task automatic present(input logic [5:0] f);
        @(posedge pclk);
        amp_fire <= f;
        repeat (TC) @(posedge pclk);
        amp_fire <= 6'h00;
    endtask : present

    task automatic run_digit(input logic [5:0] f, input int exp);
        int p0, e0, r0, k;
        logic [15:0] b0;
        p0 = trig_n;
        e0 = end_n;
        r0 = res_n;
        b0 = brk_cnt;
        k  = 0;
        present(f);
        while (res_n == r0 && k < 40 * ADV) begin
            @(posedge pclk);
            k++;
        end
        check(trig_n - p0, exp);
        check(end_n - e0, 1);
        check(res_n - r0, 1);
        check(brk_cnt - b0, exp);
        check(relay, 1'b1);
    endtask : run_digit

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        presetn  = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 8'h00;
        pwdata   = 32'h0000_0000;
        seize    = 1'b0;
        amp_fire = 6'h00;
        clk_en   = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(ADDR_CTRL, 32'h0000_0001);
        rdchk(ADDR_STAT, 32'h0000_0000);
        rdchk(ADDR_SHIFT, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000);
        check({rd[30:0], err}, 32'h0000_0001);
        $display("test reset done");
        // disabled translator ignores a digit
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        present(6'h02);
        rdchk(ADDR_STAT, 32'h0000_0000);
        rdchk(ADDR_SHIFT, 32'h0000_0000);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        $display("test enable done");
        // every digit in turn, back to back
        cum = 0;
        for (int i = 0; i < 10; i++) begin
            run_digit(fire_tab[i], i + 1);
            cum += i + 1;
            rdchk(ADDR_TRIGS, cum);
        end
        $display("test digits done");
        // hold drops once ticks stop
        n = 0;
        while (interface_hold_relay !== 1'b0 && n < 120 * TC) begin
            @(posedge pclk);
            n++;
        end
        check(interface_hold_relay, 1'b0);
        rdchk(ADDR_STAT, 32'h0000_0000);
        $display("test hold done");
        // nine loads two marks, then seizure in mid-digit
        present(6'h11);
        // a low clock enable freezes the cores before the first advance
        t0 = trig_n;
        clk_en <= 1'b0;
        repeat (2 * ADV) @(posedge pclk);
        clk_en <= 1'b1;
        check(trig_n - t0, 0);
        rdchk(ADDR_SHIFT, 32'h0000_0012);
        check(rd[0], 1'b0);
        apb(1'b0, ADDR_STAT, 32'h0000_0000);
        check(rd[STAT_ARM], 1'b1);
        repeat (3 * ADV) @(posedge pclk);
        seize <= 1'b1;
        @(posedge pclk);
        seize <= 1'b0;
        rdchk(ADDR_SHIFT, 32'h0000_0000);
        rdchk(ADDR_TRIGS, 32'h0000_0000);
        t0 = trig_n;
        repeat (4 * ADV) @(posedge pclk);
        check(trig_n - t0, 0);
        $display("test seize done");
        close_out;
    end

    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        close_out;
    end
endmodule : tb_dpt_translator
